// file: shared/sss_consts.vh
// Constants for the synchronous SRAM select, write and sleep block.
// Assumes a single rising-edge clock at 100 MHz and no software registers.
//
// Contract
// - The device is selected only when the first enable is low, the second high and the third low.
// - A full-width write happens when global write is low, or when it is high and the byte gate and all lanes are low.
// - After a write the data bus stays high impedance until a new read is started by either address strobe.
// - When sleep is left the data lines are high impedance.
// - While sleep is requested the device stays asleep and keeps its storage contents.
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH
`define SSS_AW 4
`define SSS_DW 32
`define SSS_LANES 4
`define SSS_BYTE 8
`define SSS_DEPTH 16
`define SSS_ST_IDLE 3'h1
`define SSS_ST_READ 3'h2
`define SSS_ST_SLEEP 3'h4
`endif

// file: hdl/sss_lane_write.v
// One byte lane of the storage write path.
// Assumes the parent decides when a write is legal.
`timescale 1ns/1ps
`default_nettype none
module sss_lane_write (
   input wire wr_i,
   input wire lane_n_i,
   input wire [7:0] din_i,
   input wire [7:0] old_i,
   output wire [7:0] new_o
);
   assign new_o = (wr_i && !lane_n_i) ? din_i : old_i;
endmodule
`default_nettype wire

// file: hdl/sss_sram.v
// Synchronous SRAM core: select decode, writes, read pipeline, sleep.
// Assumes all inputs except arst_n_i synchronous to clk_i; bus wire resolved outside.
`include "sss_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module sss_sram (
   input wire clk_i,
   input wire arst_n_i,
   input wire select_low_first_i,
   input wire select_high_second_i,
   input wire select_low_third_i,
   input wire proc_addr_strobe_n_i,
   input wire ctrl_addr_strobe_n_i,
   input wire global_write_n_i,
   input wire byte_write_gate_n_i,
   input wire [`SSS_LANES-1:0] lane_write_n_i,
   input wire output_enable_n_i,
   input wire sleep_request_i,
   input wire [`SSS_AW-1:0] addr_i,
   input wire [`SSS_DW-1:0] dq_i,
   output reg [`SSS_DW-1:0] dq_o,
   output wire dq_oe_n_o,
   output wire asleep_o
);
   reg [`SSS_DW-1:0] mem [0:`SSS_DEPTH-1];
   reg [2:0] state_q;
   reg [2:0] state_d;
   wire selected;
   wire strobe;
   wire full_wr;
   wire any_wr;
   wire [`SSS_LANES-1:0] lanes_n;
   wire [`SSS_DW-1:0] merged;

   assign selected = !select_low_first_i && select_high_second_i && !select_low_third_i;
   assign strobe = !proc_addr_strobe_n_i || !ctrl_addr_strobe_n_i;
   // Global write overrides the lane strobes
   assign full_wr = !global_write_n_i || (!byte_write_gate_n_i && (lane_write_n_i == {`SSS_LANES{1'b0}}));
   // Processor strobe never writes, it starts a read when the part is selected and not sleeping
   assign any_wr = !global_write_n_i || (!byte_write_gate_n_i && (lane_write_n_i != {`SSS_LANES{1'b1}}));
   assign lanes_n = full_wr ? {`SSS_LANES{1'b0}} : lane_write_n_i;

   genvar g;
   generate
      for (g = 0; g < `SSS_LANES; g = g + 1) begin : lane
         sss_lane_write u_lane (
            .wr_i(1'b1),
            .lane_n_i(lanes_n[g]),
            .din_i(dq_i[g*`SSS_BYTE +: `SSS_BYTE]),
            .old_i(mem[addr_i][g*`SSS_BYTE +: `SSS_BYTE]),
            .new_o(merged[g*`SSS_BYTE +: `SSS_BYTE])
         );
      end
   endgenerate

   wire wr_go = (state_q != `SSS_ST_SLEEP) && !sleep_request_i && selected
                && !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i && any_wr;
   wire rd_go = (state_q != `SSS_ST_SLEEP) && !sleep_request_i && selected && strobe && !wr_go;

   always @* begin
      state_d = state_q;
      case (state_q)
         `SSS_ST_IDLE, `SSS_ST_READ: begin
            if (sleep_request_i) begin
               state_d = `SSS_ST_SLEEP;
            end else if (rd_go) begin
               state_d = `SSS_ST_READ;
            end else if (strobe || wr_go) begin
               // Writes and deselected strobes float the bus until the next read
               state_d = `SSS_ST_IDLE;
            end
         end
         `SSS_ST_SLEEP: begin
            // Leave sleep with the bus floating
            if (!sleep_request_i) begin
               state_d = `SSS_ST_IDLE;
            end
         end
         default: state_d = `SSS_ST_IDLE;
      endcase
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= `SSS_ST_IDLE;
         dq_o <= {`SSS_DW{1'b0}};
      end else begin
         state_q <= state_d;
         if (rd_go) begin
            dq_o <= mem[addr_i];
         end
      end
   end

   // Array has no reset; sleep blocks writes so contents are kept
   always @(posedge clk_i) begin
      if (wr_go) begin
         mem[addr_i] <= merged;
      end
   end

   assign dq_oe_n_o = !((state_q == `SSS_ST_READ) && !output_enable_n_i && !sleep_request_i);
   assign asleep_o = (state_q == `SSS_ST_SLEEP);
endmodule
`default_nettype wire

// file: verification/sss_sram_properties.sv
// Port checks for sss_sram.
// Bound onto every sss_sram instance.
`timescale 1ns/1ps
`default_nettype none
module sss_sram_properties (
   input wire logic clk_i, arst_n_i, select_low_first_i, select_high_second_i, select_low_third_i,
   input wire logic proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, global_write_n_i, output_enable_n_i,
   input wire logic sleep_request_i, dq_oe_n_o, asleep_o);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   wire sel = !select_low_first_i && select_high_second_i && !select_low_third_i;
   wire go = sel && !sleep_request_i && !asleep_o;
   wire wr = go && !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i && !global_write_n_i;
   AST_DESEL: assert property (!sel && !proc_addr_strobe_n_i |=> dq_oe_n_o) else $error("drive kept");
   AST_WRITE: assert property (wr |=> dq_oe_n_o) else $error("drive after write");
   AST_WAKE: assert property ($fell(asleep_o) |-> dq_oe_n_o) else $error("drive on wake");
   AST_SLEEP: assert property (sleep_request_i |=> asleep_o) else $error("not asleep");
   AST_OE: assert property (output_enable_n_i |-> dq_oe_n_o) else $error("drive with oe high");
   AST_READ: assert property (go && !proc_addr_strobe_n_i ##1 (!output_enable_n_i && !sleep_request_i) |-> !dq_oe_n_o)
      else $error("no drive");
endmodule
bind sss_sram sss_sram_properties chk_u (.*);
`default_nettype wire

// file: verification/sss_ctrl_model.sv
// Controller model for the three selects.
// Fed by the bench once per cycle.
`timescale 1ns/1ps
`default_nettype none
module sss_ctrl_model (input wire logic sel_i, slp_i, output logic [2:0] ce_o);
   // Sleep wins over select so the part is never selected when entering sleep
   assign ce_o = sel_i && !slp_i ? 3'h2 : 3'h5;
endmodule
`default_nettype wire

// file: verification/sss_sram_tb_top.sv
// Bench for sss_sram with the controller model.
// Expects read data one edge after the request.
`timescale 1ns/1ps
`default_nettype none
module sss_sram_tb_top;
   // Reset starts unknown so its fall to zero is a real edge
   logic arst_n_i;
   logic clk_i = 0, sel = 0, ps = 1, cs = 1, gw = 1, bg = 1, oe = 0, zz = 0, rd = 0, rd_q = 0;
   logic [3:0] a = 0, ln = 4'hf;
   logic [31:0] d = 0, e, m [16], q [$];
   wire [31:0] dq;
   wire [2:0] ce;
   wire oe_n, asl;
   int fail_count = 0, tests_run = 0;
   sss_ctrl_model pm_u (.sel_i(sel), .slp_i(zz), .ce_o(ce));
   sss_sram dut_u (.clk_i, .arst_n_i, .select_low_first_i(ce[2]), .select_high_second_i(ce[1]),
      .select_low_third_i(ce[0]), .proc_addr_strobe_n_i(ps), .ctrl_addr_strobe_n_i(cs), .global_write_n_i(gw),
      .byte_write_gate_n_i(bg), .lane_write_n_i(ln), .output_enable_n_i(oe), .sleep_request_i(zz), .addr_i(a),
      .dq_i(d), .dq_o(dq), .dq_oe_n_o(oe_n), .asleep_o(asl));
   initial forever #5 clk_i = !clk_i;
   task finish_test;
      if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Codes: 0 idle, 1 global write, 2 lane write, 3 read, 4 sleep, 5 deselected strobe
   task op(input int k, input logic [3:0] aa);
      logic [31:0] v;
      v = $urandom;
      @(posedge clk_i);
      {sel, ps, cs, gw, bg, zz, oe, rd} <= {k inside {[1:3]}, !(k inside {3, 5}), !(k inside {1, 2}), k != 1,
         k != 2, k == 4, k == 4, k == 3};
      {ln, a, d} <= {k == 2 ? 4'h0 : 4'hf, aa, v};
      if (k == 3) q.push_back(m[aa]);
      if (k inside {1, 2}) m[aa] = v;
   endtask
   always @(posedge clk_i) rd_q <= rd;
   always @(negedge clk_i) if (rd_q) begin
      e = q.pop_front();
      tests_run++;
      if ({oe_n, dq} !== {1'b0, e}) begin
         fail_count++;
         $display("ERROR %0t exp %h got %h", $time, {1'b0, e}, {oe_n, dq});
      end
   end
   initial begin
      arst_n_i = 0;
      void'($urandom(97609));
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1;
      for (int i = 0; i < 32; i++) op(i < 16 ? 1 + i % 2 : 3, 4'(i));
      foreach (m[i]) op(i < 6 ? i % 2 * 5 : 0, 4'(i));
      for (int i = 0; i < 18; i++) op(i < 3 ? 4 : (i < 5 ? 0 : 3), 4'(i - 5));
      repeat (2) op(0, 4'h0);
      finish_test;
   end
endmodule
`default_nettype wire
